/* File: acv_converter_ctrl.sv */
// Function
// - free run: next conversion keeps old channel
// - over-reference single input gives full scale
// - reference field picks external, supply, internal
// - selection changes wait for conversion end
// - canceler sleep starts conversion once halted
// - completion raises interrupt request when done is unmasked
// - other sleep modes keep converter powered
// - single result is input times 1024 over reference
// - differential result saturating two's complement
// - alignment bit changes presented data immediately
// - input-select field chooses analog input
// - selection register resets to zero, read-write
// - input code map: single, pairs, bandgap, ground
// - right and left byte placement of result
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module acv_converter_ctrl #(
    parameter int unsigned PRESCALE = 128,
    parameter int unsigned LEVEL_W  = 12
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp,
    input  wire logic signed [LEVEL_W-1:0] analog_level,
    input  wire logic                      sleep_enter,
    input  wire logic [2:0]                sleep_mode,
    input  wire logic                      cpu_halted,
    output logic                           single_ended,
    output logic                           diff_mode,
    output logic                           bandgap_sel,
    output logic                           ground_sel,
    output logic [2:0]                     pos_input,
    output logic [2:0]                     neg_input,
    output logic                           ref_ext_sel,
    output logic                           ref_supply_sel,
    output logic                           ref_int_sel,
    output logic                           sample_hold,
    output logic                           converter_power,
    output logic                           irq
);
    typedef struct packed {
        acv_pkg::acv_state_t st;
        acv_pkg::acv_sel_t   sel;
        acv_pkg::acv_ctrl_t  ctrl;
        acv_pkg::acv_irq_t   irq_stat;
        acv_pkg::acv_irq_t   irq_mask;
        logic [4:0]          act_mux;
        logic [1:0]          act_ref;
        logic                first;
        logic                nc_arm;
        logic                sh;
        logic [4:0]          cnt;
        logic [9:0]          samp;
        logic [9:0]          code;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic [31:0]         rdata;
    } acv_regs_t;

    acv_regs_t                q;
    acv_regs_t                n;
    logic                     tick;
    logic                     accept;
    logic                     kill;
    logic [4:0]               total;
    logic [4:0]               samp_at;
    logic                     capture;
    logic                     conv_end;
    logic                     nc_mode;
    acv_pkg::acv_route_t      route;
    acv_pkg::acv_ctrl_t       wr_ctrl;
    acv_res_if #(.LW(LEVEL_W)) res();

    // routing decode of the five-bit input code
    function automatic acv_pkg::acv_route_t dec_mux(
        input logic [4:0] m
    );
        acv_pkg::acv_route_t v;
        v = '0;
        if (m <= acv_pkg::MUX_SE_LAST) begin
            v.single = 1'b1;
            v.pos    = m[2:0];
        end else if (m >= acv_pkg::MUX_DIFF_FIRST &&
                     m <= acv_pkg::MUX_DIFF_LAST) begin
            v.diff = 1'b1;
            v.pos  = m[2:0];
            v.neg  = m[3] ? acv_pkg::NEG_HIGH_PAIR
                          : acv_pkg::NEG_LOW_PAIR;
        end else if (m == acv_pkg::MUX_BANDGAP) begin
            v.bandgap = 1'b1;
        end else if (m == acv_pkg::MUX_GROUND) begin
            v.ground = 1'b1;
        end
        return v;
    endfunction

    acv_prescaler #(
        .DIV (PRESCALE)
    ) u_prescaler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (q.ctrl.converter_enable),
        .tick    (tick)
    );

    acv_result_fmt u_fmt (
        .r (res.fmt)
    );

    // feed the formatter from the locked routing, the live alignment bit and the result
    assign res.level = analog_level;
    assign res.diff  = route.diff;
    assign res.code  = q.code;
    assign res.left  = q.sel.left_align_result;

    // bus qualifiers and conversion timing terms
    assign accept   = hsel && htrans[1] && hready;
    assign wr_ctrl  = acv_pkg::acv_ctrl_t'(hwdata[7:0]);
    // a start written together with the enable must survive
    assign kill     = (q.wr_pend && q.wr_addr == acv_pkg::ADDR_CTRL)
                      ? !wr_ctrl.converter_enable
                      : !q.ctrl.converter_enable;
    assign total    = q.first ? acv_pkg::FIRST_TICKS
                              : acv_pkg::NORMAL_TICKS;
    assign samp_at  = q.first ? acv_pkg::FIRST_SAMPLE
                              : acv_pkg::NORMAL_SAMPLE;
    assign capture  = q.st == acv_pkg::ST_CONV && tick && !kill &&
                      (q.cnt + 5'h01) == samp_at;
    assign conv_end = q.st == acv_pkg::ST_CONV && tick && !kill &&
                      (q.cnt + 5'h01) == total;
    assign nc_mode  = sleep_mode == acv_pkg::SLP_IDLE ||
                      sleep_mode == acv_pkg::SLP_NOISE;

    // next-state of the whole block
    always_comb begin
        n = q;
        n.sh = 1'b0;
        n.wr_pend = 1'b0;
        // address phase: latch writes, answer reads
        if (accept) begin
            if (hwrite) begin
                n.wr_pend = 1'b1;
                n.wr_addr = haddr[acv_pkg::ADDR_W-1:0];
            end else begin
                case (haddr[acv_pkg::ADDR_W-1:0])
                    acv_pkg::ADDR_SEL: begin
                        n.rdata = 32'(q.sel);
                    end
                    acv_pkg::ADDR_CTRL: begin
                        n.rdata = 32'(q.ctrl);
                    end
                    acv_pkg::ADDR_RESULT: begin
                        n.rdata = 32'({res.high_byte, res.low_byte});
                    end
                    acv_pkg::ADDR_IRQ_STAT: begin
                        n.rdata = 32'(q.irq_stat);
                        n.irq_stat = '0;
                    end
                    acv_pkg::ADDR_IRQ_MASK: begin
                        n.rdata = 32'(q.irq_mask);
                    end
                    default: begin
                        n.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        // data phase: commit the latched write
        if (q.wr_pend) begin
            case (q.wr_addr)
                acv_pkg::ADDR_SEL: begin
                    n.sel = acv_pkg::acv_sel_t'(hwdata[7:0]);
                end
                acv_pkg::ADDR_CTRL: begin
                    n.ctrl.converter_enable = wr_ctrl.converter_enable;
                    n.ctrl.free_run = wr_ctrl.free_run;
                    n.ctrl.int_enable = wr_ctrl.int_enable;
                    if (wr_ctrl.conversion_start_bit) begin
                        n.ctrl.conversion_start_bit = 1'b1;
                    end
                    if (wr_ctrl.conversion_done_flag) begin
                        n.ctrl.conversion_done_flag = 1'b0;
                    end
                end
                acv_pkg::ADDR_IRQ_MASK: begin
                    n.irq_mask = acv_pkg::acv_irq_t'(hwdata[1:0]);
                end
                default: begin
                end
            endcase
        end
        // noise canceler: arm on sleep entry, start once halted
        if (sleep_enter && nc_mode && q.ctrl.converter_enable &&
            q.st == acv_pkg::ST_IDLE &&
            !q.ctrl.conversion_start_bit &&
            !q.ctrl.free_run && q.ctrl.int_enable) begin
            n.nc_arm = 1'b1;
        end
        if (q.nc_arm && cpu_halted) begin
            n.nc_arm = 1'b0;
            n.ctrl.conversion_start_bit = 1'b1;
            n.irq_stat.sleep_start = 1'b1;
        end
        // other sleep modes leave power and state untouched
        // conversion sequencer
        if (kill) begin
            n.st = acv_pkg::ST_IDLE;
            n.ctrl.conversion_start_bit = 1'b0;
            n.first = 1'b1;
            n.nc_arm = 1'b0;
            n.cnt = 5'h00;
            n.act_mux = q.sel.input_select;
            n.act_ref = q.sel.reference_select;
        end else begin
            case (q.st)
                acv_pkg::ST_IDLE: begin
                    // selection tracks software while idle
                    n.act_mux = q.sel.input_select;
                    n.act_ref = q.sel.reference_select;
                    if (n.ctrl.conversion_start_bit) begin
                        n.st = acv_pkg::ST_PEND;
                    end
                end
                acv_pkg::ST_PEND: begin
                    // keeps tracking until the converter edge
                    n.act_mux = q.sel.input_select;
                    n.act_ref = q.sel.reference_select;
                    if (tick) begin
                        n.st = acv_pkg::ST_CONV;
                        n.cnt = 5'h00;
                    end
                end
                acv_pkg::ST_CONV: begin
                    // selection locked here until the end
                    if (tick) begin
                        n.cnt = q.cnt + 5'h01;
                    end
                    if (capture) begin
                        n.samp = res.sat_code;
                        n.sh = 1'b1;
                    end
                    if (conv_end) begin
                        n.code = q.samp;
                        n.ctrl.conversion_done_flag = 1'b1;
                        n.irq_stat.done = 1'b1;
                        n.first = 1'b0;
                        n.cnt = 5'h00;
                        n.act_mux = q.sel.input_select;
                        n.act_ref = q.sel.reference_select;
                        if (!n.ctrl.free_run) begin
                            n.st = acv_pkg::ST_IDLE;
                            n.ctrl.conversion_start_bit = 1'b0;
                        end
                        // free run restarts on the selection seen now;
                        // later writes reach only the one after
                    end
                end
                default: begin
                    n.st = acv_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= acv_pkg::ST_IDLE;
            q.sel <= acv_pkg::SEL_RESET;
            q.first <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // routing and reference outputs from the locked selection
    assign route          = dec_mux(q.act_mux);
    assign single_ended   = route.single;
    assign diff_mode      = route.diff;
    assign bandgap_sel    = route.bandgap;
    assign ground_sel     = route.ground;
    assign pos_input      = route.pos;
    assign neg_input      = route.neg;
    assign ref_ext_sel    = q.act_ref == acv_pkg::REF_EXT;
    assign ref_supply_sel = q.act_ref == acv_pkg::REF_SUPPLY;
    assign ref_int_sel    = q.act_ref == acv_pkg::REF_INT;

    // remaining outputs
    assign sample_hold     = q.sh;
    assign converter_power = q.ctrl.converter_enable;
    assign irq             = |(q.irq_stat & q.irq_mask);
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = q.rdata;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence sel_write_s;
        q.wr_pend && q.wr_addr == acv_pkg::ADDR_SEL;
    endsequence

    sequence conv_hold_s;
        q.st == acv_pkg::ST_CONV && !conv_end && !kill;
    endsequence

    sequence nc_go_s;
        q.nc_arm && cpu_halted && !kill &&
        q.st == acv_pkg::ST_IDLE;
    endsequence

    sequence free_end_s;
        conv_end && q.ctrl.free_run && !q.wr_pend;
    endsequence

    sel_store_a: assert property (
        sel_write_s |=> q.sel == $past(hwdata[7:0]))
        else $error("selection write not stored");

    lock_sel_a: assert property (
        conv_hold_s |=> $stable(q.act_mux) && $stable(q.act_ref))
        else $error("selection moved during conversion");

    end_flag_a: assert property (
        conv_end |=> q.ctrl.conversion_done_flag && q.irq_stat.done)
        else $error("completion did not set flags");

    free_old_a: assert property (
        free_end_s |=> q.st == acv_pkg::ST_CONV &&
                       q.cnt == 5'h00 &&
                       q.act_mux == $past(q.sel.input_select))
        else $error("free run restart used wrong channel");

    full_scale_a: assert property (
        capture && !res.diff && analog_level > acv_pkg::SE_MAX
        |=> q.samp == acv_pkg::CODE_FULL)
        else $error("over-reference input not full scale");

    se_code_a: assert property (
        capture && !res.diff && analog_level >= 0 &&
        analog_level <= acv_pkg::SE_MAX
        |=> q.samp == $past(analog_level[9:0]))
        else $error("single-ended code wrong");

    diff_low_a: assert property (
        capture && res.diff && analog_level < acv_pkg::DIFF_MIN
        |=> q.samp == acv_pkg::CODE_NEG_FULL)
        else $error("differential low end not saturated");

    align_left_a: assert property (
        q.sel.left_align_result |->
        {res.high_byte, res.low_byte} == {q.code, 6'h00})
        else $error("left aligned bytes wrong");

    ref_int_a: assert property (
        q.act_ref == acv_pkg::REF_INT |->
        ref_int_sel && !ref_ext_sel && !ref_supply_sel)
        else $error("internal reference not selected");

    gnd_sel_a: assert property (
        q.act_mux == acv_pkg::MUX_GROUND |->
        ground_sel && !diff_mode && !single_ended)
        else $error("ground code decoded wrong");

    nc_start_a: assert property (
        nc_go_s |=> q.st == acv_pkg::ST_PEND &&
                    q.ctrl.conversion_start_bit)
        else $error("halt did not start conversion");

    power_keep_a: assert property (
        sleep_enter && !nc_mode && q.ctrl.converter_enable &&
        !q.wr_pend |=> converter_power)
        else $error("converter lost power in sleep");
endmodule
`default_nettype wire

/* File: acv_pkg.sv */
`default_nettype none
package acv_pkg;
    // register map, byte addresses on the bus
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CTRL     = 8'h70;
    localparam logic [7:0]  ADDR_RESULT   = 8'h74;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h78;
    localparam logic [7:0]  ADDR_SEL      = 8'h7C;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h80;

    // converter_input_ref_select layout
    typedef struct packed {
        logic [1:0] reference_select;
        logic       left_align_result;
        logic [4:0] input_select;
    } acv_sel_t;
    localparam acv_sel_t SEL_RESET = 8'h00;

    // converter_control_status layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic       int_enable;
        logic       conversion_done_flag;
        logic       free_run;
        logic       conversion_start_bit;
        logic       converter_enable;
    } acv_ctrl_t;

    // interrupt status and mask layout
    typedef struct packed {
        logic sleep_start;
        logic done;
    } acv_irq_t;

    // analog routing decoded from input_select
    typedef struct packed {
        logic       single;
        logic       diff;
        logic       bandgap;
        logic       ground;
        logic [2:0] pos;
        logic [2:0] neg;
    } acv_route_t;

    // reference codes
    localparam logic [1:0] REF_EXT    = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_INT    = 2'h3;

    // input-select codes
    localparam logic [4:0] MUX_SE_LAST    = 5'h07;
    localparam logic [4:0] MUX_DIFF_FIRST = 5'h10;
    localparam logic [4:0] MUX_DIFF_LAST  = 5'h1D;
    localparam logic [4:0] MUX_BANDGAP    = 5'h1E;
    localparam logic [4:0] MUX_GROUND     = 5'h1F;
    localparam logic [2:0] NEG_LOW_PAIR   = 3'h1;
    localparam logic [2:0] NEG_HIGH_PAIR  = 3'h2;

    // converter clock counts
    localparam logic [4:0] NORMAL_TICKS  = 5'h0D;
    localparam logic [4:0] FIRST_TICKS   = 5'h19;
    localparam logic [4:0] NORMAL_SAMPLE = 5'h01;
    localparam logic [4:0] FIRST_SAMPLE  = 5'h0D;

    // result codes and limits
    localparam int         SE_MAX        = 1023;
    localparam int         DIFF_MAX      = 511;
    localparam int         DIFF_MIN      = -512;
    localparam logic [9:0] CODE_ZERO     = 10'h000;
    localparam logic [9:0] CODE_FULL     = 10'h3FF;
    localparam logic [9:0] CODE_POS_FULL = 10'h1FF;
    localparam logic [9:0] CODE_NEG_FULL = 10'h200;

    // sleep modes that run the noise canceler
    localparam logic [2:0] SLP_IDLE  = 3'h0;
    localparam logic [2:0] SLP_NOISE = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PEND = 3'b010,
        ST_CONV = 3'b100
    } acv_state_t;
endpackage
`default_nettype wire

/* File: acv_res_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface acv_res_if #(parameter int unsigned LW = 12);
    logic signed [LW-1:0] level;
    logic                 diff;
    logic [9:0]           sat_code;
    logic [9:0]           code;
    logic                 left;
    logic [7:0]           high_byte;
    logic [7:0]           low_byte;
    modport core (output level, diff, code, left,
                  input  sat_code, high_byte, low_byte);
    modport fmt  (input  level, diff, code, left,
                  output sat_code, high_byte, low_byte);
endinterface
`default_nettype wire

/* File: acv_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module acv_prescaler #(
    parameter int unsigned DIV = 128
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    output logic      tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } acv_ps_t;

    acv_ps_t q;
    acv_ps_t n;

    // held in reset while the converter is off
    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = '0;
        end else if (q.cnt == CW'(DIV - 1)) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick = q.tick;
endmodule
`default_nettype wire

/* File: acv_result_fmt.sv */
`timescale 1ns/10ps
`default_nettype none
module acv_result_fmt (
    acv_res_if.fmt r
);
    // clamp the scaled level into the code range
    always_comb begin
        if (r.diff) begin
            if (r.level > acv_pkg::DIFF_MAX) begin
                r.sat_code = acv_pkg::CODE_POS_FULL;
            end else if (r.level < acv_pkg::DIFF_MIN) begin
                r.sat_code = acv_pkg::CODE_NEG_FULL;
            end else begin
                r.sat_code = r.level[9:0];
            end
        end else begin
            if (r.level > acv_pkg::SE_MAX) begin
                r.sat_code = acv_pkg::CODE_FULL;
            end else if (r.level < 0) begin
                r.sat_code = acv_pkg::CODE_ZERO;
            end else begin
                r.sat_code = r.level[9:0];
            end
        end
    end

    // byte presentation follows the alignment bit at once
    always_comb begin
        if (r.left) begin
            {r.high_byte, r.low_byte} = {r.code, 6'h00};
        end else begin
            {r.high_byte, r.low_byte} = {6'h00, r.code};
        end
    end
endmodule
`default_nettype wire

/* File: acv_converter_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module acv_converter_ctrl_tb;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0000_0000;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [2:0]         hsize = 3'h2;
    logic [31:0]        hwdata = 32'h0000_0000;
    logic signed [11:0] analog_level = 12'sh000;
    logic               sleep_enter = 1'b0;
    logic [2:0]         sleep_mode = 3'h0;
    logic               cpu_halted = 1'b0;
    logic [31:0]        hrdata, rd;
    logic [2:0]         pos_input, neg_input;
    logic               hreadyout, hresp, single_ended, diff_mode, bandgap_sel;
    logic               ground_sel, ref_ext_sel, ref_supply_sel, ref_int_sel;
    logic               sample_hold, converter_power, irq;
    logic [7:0]         v;
    logic [15:0]        rnd = 16'h004f;
    wire                hready = hreadyout;
    int                 bad_count = 0;
    int                 total_checks = 0;
    int                 cyc = 0;
    int                 sh_n = 0;
    int                 lv[6] = '{300, 2000, -93, -2000, 1500, 0};
    logic [4:0]         cs[6] = '{5'h03, 5'h05, 5'h1b, 5'h11, 5'h12, 5'h00};

    acv_converter_ctrl #(.PRESCALE(2), .LEVEL_W(12)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .analog_level, .sleep_enter,
        .sleep_mode, .cpu_halted, .single_ended, .diff_mode, .bandgap_sel,
        .ground_sel, .pos_input, .neg_input, .ref_ext_sel, .ref_supply_sel,
        .ref_int_sel, .sample_hold, .converter_power, .irq);

    // free-running bus clock
    always #20 hclk = ~hclk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // expected {single, diff, bandgap, ground, pos, neg} for a code
    function automatic logic [9:0] route_exp(input logic [4:0] m);
        if (m <= 5'h07) return {4'b1000, m[2:0], 3'h0};
        if (m >= 5'h10 && m <= 5'h1d) return {4'b0100, m[2:0], m[3] ? 3'h2 : 3'h1};
        if (m == 5'h1e) return 10'h080;
        if (m == 5'h1f) return 10'h040;
        return 10'h000;
    endfunction

    function automatic logic [2:0] ref_exp(input logic [1:0] r);
        return r == 2'h0 ? 3'h4 : r == 2'h1 ? 3'h2 : r == 2'h3 ? 3'h1 : 3'h0;
    endfunction

    // clamped code placed per alignment
    function automatic logic [15:0] res_exp(input int l, input logic d, input logic lft);
        int c;
        if (d) c = l > acv_pkg::DIFF_MAX ? acv_pkg::DIFF_MAX : (l < acv_pkg::DIFF_MIN ? acv_pkg::DIFF_MIN : l);
        else c = l > acv_pkg::SE_MAX ? acv_pkg::SE_MAX : (l < 0 ? 0 : l);
        return lft ? {c[9:0], 6'h00} : {6'h00, c[9:0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one single-word transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // poll until the start bit reads low
    task automatic wait_done();
        do bus(1'b0, acv_pkg::ADDR_CTRL, 32'h0); while (rd[1] !== 1'b0);
    endtask

    task automatic chk_route(input logic [7:0] s);
        logic [9:0] g;
        g = {single_ended, diff_mode, bandgap_sel, ground_sel, pos_input, neg_input};
        chk("route", 32'(g), 32'(route_exp(s[4:0])));
        chk("ref", 32'({ref_ext_sel, ref_supply_sel, ref_int_sel}), 32'(ref_exp(s[7:6])));
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (sample_hold) sh_n <= sh_n + 1;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, acv_pkg::ADDR_SEL, 32'h0);
        chk("sel reset", rd, 32'h0);
        chk("resp", 32'(hresp), 32'h0);
        chk_route(8'h00);
        bus(1'b1, 8'h90, 32'hffff_ffff);
        bus(1'b0, 8'h90, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            v = {i[1:0], rnd[0], i[4:0]};
            bus(1'b1, acv_pkg::ADDR_SEL, {24'h00_0000, v});
            bus(1'b0, acv_pkg::ADDR_SEL, 32'h0);
            chk("sel readback", rd, {24'h00_0000, v});
            chk_route(v);
        end
        $display("test select sweep done");
        bus(1'b1, acv_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            if (k == 5) lv[5] = int'(rnd[9:0]);
            // reference moves each pass; ideal levels need no discard
            v = {rnd[7:6], rnd[1], cs[k]};
            bus(1'b1, acv_pkg::ADDR_SEL, {24'h00_0000, v});
            analog_level <= 12'(lv[k]);
            bus(1'b1, acv_pkg::ADDR_CTRL, 32'h0000_0013);
            wait_done();
            chk("irq", 32'(irq), 32'h1);
            chk("samples", 32'(sh_n), 32'(k + 1));
            bus(1'b0, acv_pkg::ADDR_RESULT, 32'h0);
            chk("result", rd, 32'(res_exp(lv[k], v[4], v[5])));
            bus(1'b1, acv_pkg::ADDR_SEL, {24'h00_0000, v ^ 8'h20});
            bus(1'b0, acv_pkg::ADDR_RESULT, 32'h0);
            chk("realign", rd, 32'(res_exp(lv[k], v[4], ~v[5])));
            bus(1'b0, acv_pkg::ADDR_IRQ_STAT, 32'h0);
            chk("status", rd, 32'h1);
            @(posedge hclk);
            chk("irq clear", 32'(irq), 32'h0);
        end
        $display("test conversions done");
        bus(1'b1, acv_pkg::ADDR_SEL, 32'h0000_0042);
        bus(1'b1, acv_pkg::ADDR_CTRL, 32'h0000_0013);
        repeat (4) @(posedge hclk); // a converter clock first
        bus(1'b1, acv_pkg::ADDR_SEL, 32'h0000_00c6);
        @(posedge hclk);
        chk("locked", 32'({pos_input, ref_supply_sel}), 32'h5);
        wait_done();
        chk("released", 32'({pos_input, ref_int_sel}), 32'hd);
        bus(1'b0, acv_pkg::ADDR_IRQ_STAT, 32'h0);
        $display("test locking done");
        bus(1'b1, acv_pkg::ADDR_CTRL, 32'h0000_0011); // idle, irq on
        sleep_mode <= 3'h1;
        sleep_enter <= 1'b1;
        @(posedge hclk);
        sleep_enter <= 1'b0;
        cpu_halted <= 1'b1;
        repeat (3) @(posedge hclk);
        wait_done();
        cpu_halted <= 1'b0;
        bus(1'b0, acv_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("sleep start", rd, 32'h3);
        sleep_mode <= 3'h2;
        sleep_enter <= 1'b1;
        @(posedge hclk);
        sleep_enter <= 1'b0;
        cpu_halted <= 1'b1;
        repeat (20) @(posedge hclk);
        chk("power", 32'(converter_power), 32'h1);
        bus(1'b0, acv_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("no launch", rd, 32'h0);
        $display("test sleep done");
        // free run: a change after the first result reaches the third
        analog_level <= -12'sd93;
        bus(1'b1, acv_pkg::ADDR_SEL, 32'h0000_0003);
        bus(1'b1, acv_pkg::ADDR_CTRL, 32'h0000_0017);
        for (int f = 0; f < 3; f++) begin
            do bus(1'b0, acv_pkg::ADDR_IRQ_STAT, 32'h0);
            while (rd[0] !== 1'b1);
            bus(1'b0, acv_pkg::ADDR_RESULT, 32'h0);
            chk("free run", rd, f == 2 ? 32'h0000_03a3 : 32'h0);
            if (f == 0) bus(1'b1, acv_pkg::ADDR_SEL, 32'h0000_001b);
        end
        bus(1'b1, acv_pkg::ADDR_CTRL, 32'h0000_0010);
        $display("test free run done");
        finish_test();
    end
endmodule
`default_nettype wire
